// ---- hw/buck_boost_pkg.sv ----
package buck_boost_pkg;

  // ----------------------------------------------------------------
  // Target addresses and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SEL_LOW  = 7'h75;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h74;
  localparam logic [7:0] REG_REF_LO    = 8'h00;
  localparam logic [7:0] REG_REF_HI    = 8'h01;
  localparam logic [7:0] REG_ILIM      = 8'h02;
  localparam logic [7:0] REG_SLEW      = 8'h03;
  localparam logic [7:0] REG_FB        = 8'h04;
  localparam logic [7:0] REG_DROOP     = 8'h05;
  localparam logic [7:0] REG_OP        = 8'h06;
  localparam logic [7:0] REG_STAT      = 8'h07;
  localparam int         CFG_REGS      = 7;

  // Values after reset, indexed by register offset 00h to 06h.
  localparam logic [7:0] CFG_RESET [0:CFG_REGS-1] =
    '{8'ha4, 8'h01, 8'he4, 8'h00, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ILIM_EN_BIT   = 7;
  localparam int FB_SRC_BIT    = 7;
  localparam int OP_RUN_BIT    = 7;
  localparam int OP_HICCUP_BIT = 5;
  localparam int OP_FORCED_FIXED_FREQ_OPERATION_BIT   = 1;
  localparam int STAT_HOT_BIT  = 0;
  localparam int STAT_SC_BIT   = 1;
  localparam int STAT_OVP_BIT  = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 10000;
  localparam int SS_TIME_US     = 3600;
  localparam int SC_TIME_US     = 2000;
  localparam int HICCUP_TIME_US = 76000;
  localparam int SS_CYCLES      = SS_TIME_US * CLK_KHZ / 1000;
  localparam int SC_CYCLES      = SC_TIME_US * CLK_KHZ / 1000;
  localparam int HICCUP_CYCLES  = HICCUP_TIME_US * CLK_KHZ / 1000;
  localparam int REF_STEPS      = 2048;
  localparam int TMR_W          = 20;

  typedef enum logic [2:0] {
    CV_IDLE    = 3'b000,
    CV_SOFT    = 3'b001,
    CV_RUN     = 3'b010,
    CV_HICCUP  = 3'b011,
    CV_THERMAL = 3'b100
  } conv_state_t;

  typedef enum logic [3:0] {
    BS_IDLE  = 4'b0000, BS_ADDR  = 4'b0001, BS_AACK  = 4'b0010,
    BS_REG   = 4'b0011, BS_RACK  = 4'b0100, BS_WDATA = 4'b0101,
    BS_WACK  = 4'b0110, BS_RDATA = 4'b0111, BS_MACK  = 4'b1000
  } bus_state_t;

  // True for an offset that names a defined register.
  function automatic logic addr_ok(input logic [7:0] a);
    return a <= REG_STAT;
  endfunction

endpackage

// ---- hw/buck_boost_control_sequencer.sv ----
// Notes on behaviour
// [R01] Feedback source bit picks internal divider (0) or external divider (1).
// [R02] Two-bit internal divider field selects one of four feedback ratios.
// [R03] Reference is an 11-bit code taken from registers 00h and 01h.
// [R04] Droop compensation defaults on with zero offset; three-bit level field.
// [R05] Current limit code gives sense voltage in 0.5mV steps.
// [R06] Clearing the limit enable bit disables output current limiting.
// [R07] Overvoltage: both high sides off, both low sides on until released.
// [R08] Hiccup protection acts only when the hiccup enable bit is set.
// [R09] Short-circuit watch starts only after the soft-start period ends.
// [R10] Limit plus low output for 2ms stops switching 76ms, then soft start.
// [R11] Over-temperature shuts down and resets soft start, registers kept.
// [R12] Restart automatically once the temperature indication clears.
// [R13] Pulse skipping by default; forced fixed frequency when bit 1 set.
// [R14] Fixed frequency keeps high side on at zero current.
// [R15] Pulse skipping in buck region turns buck low side off at zero.
// [R16] Pulse skipping in boost region stops boost high side until output drops.
// [R17] Bus target address is 74h or 75h by address select pin.
// [R18] Registers 00h to 07h are readable and writable over the bus; the code drops writes to 07h.
// [R19] Bus works up to 100 and 1000 kbit/s.
// [R20] Setting run bit ramps reference from zero over about 3.6ms.
// [R21] Undefined register address gets NACK and the bus goes idle.
// [R22] Enable pin low resets every register and disables everything; the code keeps the overvoltage clamp driving both low sides on.
// [R23] Hiccup intervals use clocked counters restarted when the fault clears.
// [R24] Comparator indications are synchronised before use.
module buck_boost_control_sequencer
  import buck_boost_pkg::*;
#(
  parameter int SS_CYC  = SS_CYCLES,
  parameter int SC_CYC  = SC_CYCLES,
  parameter int HIC_CYC = HICCUP_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        enable_threshold_pin_in,
  input  wire logic        addr_select_in,
  input  wire logic        overvoltage_in,
  input  wire logic        current_at_limit_in,
  input  wire logic        output_below_min_in,
  input  wire logic        over_temp_in,
  input  wire logic        inductor_zero_in,
  input  wire logic        output_dropped_in,
  input  wire logic        boost_region_in,
  input  wire logic        pwm_buck_in,
  input  wire logic        pwm_boost_in,
  output logic             sda_out_out,
  output logic             sda_oe_out,
  output logic [10:0]      ref_code_out,
  output logic             feedback_source_select_out,
  output logic [1:0]       internal_divider_ratio_out,
  output logic [2:0]       droop_comp_level_out,
  output logic [6:0]       current_limit_code_out,
  output logic             current_limit_en_out,
  output logic             forced_fixed_freq_operation_out,
  output logic             buck_hs_on_out,
  output logic             buck_ls_on_out,
  output logic             boost_hs_on_out,
  output logic             boost_ls_on_out
);

  localparam int STEP_CYC = (SS_CYC >= 2 * REF_STEPS) ? SS_CYC / REF_STEPS : 1;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  // Every pin and comparator except boost_region_in and the two PWM inputs passes two flops before any logic reads it.
  // [R24] comparator synchronising
  // Bus lines and enable preset high, the comparator flags preset quiet,
  // so that no false clamp or thermal trip follows the release of reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 10'h380;
      sync2_reg <= 10'h380;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {scl_in, sda_in, enable_threshold_pin_in, addr_select_in,
                    overvoltage_in, current_at_limit_in, output_below_min_in,
                    over_temp_in, inductor_zero_in, output_dropped_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[9];
      sda_d_reg <= sync2_reg[8];
    end
  end

  logic scl_s, sda_s, en_s, asel_s, ovp_s, ilim_s, vlow_s, hot_s;
  logic izero_s, vdrop_s;
  assign {scl_s, sda_s, en_s, asel_s, ovp_s, ilim_s, vlow_s, hot_s,
          izero_s, vdrop_s} = sync2_reg;

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s && !scl_d_reg;
  assign scl_fall  = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && !sda_s && sda_d_reg;
  assign bus_stop  = scl_s && scl_d_reg && sda_s && !sda_d_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  cfg_reg [0:CFG_REGS-1];
  logic [7:0]  status;
  conv_state_t cv_reg;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  shift_reg;

  assign status = {5'h00, ovp_s, cv_reg == CV_HICCUP, cv_reg == CV_THERMAL};

  // Status at 07h is read-only; writes there are acknowledged and dropped.
  // [R18] register writes
  // [R22] enable pin reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CFG_REGS; i++) cfg_reg[i] <= CFG_RESET[i];
    end else if (!en_s) begin
      for (int i = 0; i < CFG_REGS; i++) cfg_reg[i] <= CFG_RESET[i];
    end else if (wr_en && wr_addr < REG_STAT) begin
      cfg_reg[wr_addr[2:0]] <= shift_reg;
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] a);
    if (a == REG_STAT) return status;
    if (a < REG_STAT) return cfg_reg[a[2:0]];
    return 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Bus target
  // ----------------------------------------------------------------
  bus_state_t bs_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic       oe_reg;
  logic       mack_reg;
  logic [6:0] own_addr;
  logic [7:0] rd_now;
  logic [7:0] rd_next;

  // [R17] address by select pin
  assign own_addr = asel_s ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
  assign wr_en    = scl_fall && bs_reg == BS_WDATA && bit_cnt_reg == 4'h8
                    && addr_ok(ptr_reg);
  assign wr_addr  = ptr_reg;

  // Read data at the pointer and at the one after it, for byte loads.
  always_comb begin
    rd_now  = read_mux(ptr_reg);
    rd_next = read_mux(ptr_reg + 8'h01);
  end

  // Bits are taken on SCL rise and driven on SCL fall; ten samples per bit
  // at the top rate leave enough margin for the two-flop input delay.
  // [R19] edge-driven target
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bs_reg <= BS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (!en_s || bus_stop) begin
      bs_reg <= BS_IDLE;
      oe_reg <= 1'b0;
    end else if (bus_start) begin
      bs_reg <= BS_ADDR;
      bit_cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (scl_rise) begin
      shift_reg <= {shift_reg[6:0], sda_s};
      mack_reg <= !sda_s;
      if (bs_reg inside {BS_ADDR, BS_REG, BS_WDATA, BS_RDATA})
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (scl_fall) begin
      unique case (bs_reg)
        BS_IDLE: oe_reg <= 1'b0;
        BS_ADDR: if (bit_cnt_reg == 4'h8) begin
          if (shift_reg[7:1] == own_addr) begin
            oe_reg <= 1'b1;
            bs_reg <= BS_AACK;
          end else begin
            bs_reg <= BS_IDLE;
          end
        end
        BS_AACK: begin
          bit_cnt_reg <= 4'h0;
          // The ack rise shifted once more, so the direction bit is bit 1.
          if (shift_reg[1]) begin
            tx_reg <= rd_now;
            oe_reg <= !rd_now[7];
            bs_reg <= BS_RDATA;
          end else begin
            oe_reg <= 1'b0;
            bs_reg <= BS_REG;
          end
        end
        // [R21] undefined address NACK
        BS_REG: if (bit_cnt_reg == 4'h8) begin
          ptr_reg <= shift_reg;
          oe_reg <= addr_ok(shift_reg);
          bs_reg <= addr_ok(shift_reg) ? BS_RACK : BS_IDLE;
        end
        BS_RACK, BS_WACK: begin
          oe_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
          bs_reg <= BS_WDATA;
        end
        BS_WDATA: if (bit_cnt_reg == 4'h8) begin
          oe_reg <= addr_ok(ptr_reg);
          bs_reg <= addr_ok(ptr_reg) ? BS_WACK : BS_IDLE;
          ptr_reg <= ptr_reg + 8'h01;
        end
        BS_RDATA: if (bit_cnt_reg == 4'h8) begin
          oe_reg <= 1'b0;
          bs_reg <= BS_MACK;
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          oe_reg <= !tx_reg[6];
        end
        BS_MACK: if (mack_reg) begin
          bit_cnt_reg <= 4'h0;
          tx_reg <= rd_next;
          oe_reg <= !rd_next[7];
          ptr_reg <= ptr_reg + 8'h01;
          bs_reg <= BS_RDATA;
        end else begin
          bs_reg <= BS_IDLE;
        end
        default: bs_reg <= BS_IDLE;
      endcase
    end
  end

  assign sda_out_out = 1'b0;
  assign sda_oe_out  = oe_reg;

  // ----------------------------------------------------------------
  // Converter sequencing
  // ----------------------------------------------------------------
  logic              run_bit, hiccup_en, fault_sc;
  logic [TMR_W-1:0]  tmr_reg;
  logic [10:0]       target, ramp_reg;
  logic [TMR_W-1:0]  step_reg;

  assign run_bit   = cfg_reg[REG_OP[2:0]][OP_RUN_BIT];
  // [R08] hiccup gated by enable
  assign hiccup_en = cfg_reg[REG_OP[2:0]][OP_HICCUP_BIT];
  assign fault_sc  = hiccup_en && ilim_s && vlow_s;
  // [R03] eleven-bit reference code
  assign target    = {cfg_reg[REG_REF_HI[2:0]][2:0], cfg_reg[REG_REF_LO[2:0]]};

  // One shared timer counts soft start, fault time and off time in turn.
  // [R09] watch after soft start
  // [R10] hiccup timing
  // [R11] thermal shutdown
  // [R12] automatic restart
  // [R23] counters restart
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cv_reg <= CV_IDLE;
      tmr_reg <= '0;
    end else if (!en_s || hot_s) begin
      cv_reg <= en_s ? CV_THERMAL : CV_IDLE;
      tmr_reg <= '0;
    end else begin
      unique case (cv_reg)
        CV_IDLE: begin
          tmr_reg <= '0;
          if (run_bit) cv_reg <= CV_SOFT;
        end
        CV_SOFT: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (!run_bit) cv_reg <= CV_IDLE;
          else if (tmr_reg == TMR_W'(SS_CYC - 1)) begin
            cv_reg <= CV_RUN;
            tmr_reg <= '0;
          end
        end
        CV_RUN: begin
          tmr_reg <= fault_sc ? tmr_reg + 1'b1 : '0;
          if (!run_bit) cv_reg <= CV_IDLE;
          else if (fault_sc && tmr_reg == TMR_W'(SC_CYC - 1)) begin
            cv_reg <= CV_HICCUP;
            tmr_reg <= '0;
          end
        end
        CV_HICCUP: begin
          tmr_reg <= tmr_reg + 1'b1;
          if (tmr_reg == TMR_W'(HIC_CYC - 1)) begin
            cv_reg <= run_bit ? CV_SOFT : CV_IDLE;
            tmr_reg <= '0;
          end
        end
        CV_THERMAL: cv_reg <= run_bit ? CV_SOFT : CV_IDLE;
        default: cv_reg <= CV_IDLE;
      endcase
    end
  end

  // The ramp steps one code per interval, so any target is met in time when SS_CYC is at least REF_STEPS.
  // [R20] reference ramp
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_reg <= 11'h000;
      step_reg <= '0;
    end else if (cv_reg == CV_RUN) begin
      ramp_reg <= target;
    end else if (cv_reg == CV_SOFT) begin
      step_reg <= (step_reg == TMR_W'(STEP_CYC - 1)) ? '0 : step_reg + 1'b1;
      if (step_reg == TMR_W'(STEP_CYC - 1) && ramp_reg < target)
        ramp_reg <= ramp_reg + 11'h001;
    end else begin
      ramp_reg <= 11'h000;
      step_reg <= '0;
    end
  end

  assign ref_code_out = ramp_reg;
  // [R01] feedback source select
  assign feedback_source_select_out = cfg_reg[REG_FB[2:0]][FB_SRC_BIT];
  // [R02] divider ratio field
  assign internal_divider_ratio_out = cfg_reg[REG_FB[2:0]][1:0];
  // [R04] droop level field
  assign droop_comp_level_out = cfg_reg[REG_DROOP[2:0]][2:0];
  // [R05] half-millivolt limit code
  assign current_limit_code_out = cfg_reg[REG_ILIM[2:0]][6:0];
  // [R06] limit enable bit
  assign current_limit_en_out = cfg_reg[REG_ILIM[2:0]][ILIM_EN_BIT];
  // [R13] forced fixed frequency
  assign forced_fixed_freq_operation_out = cfg_reg[REG_OP[2:0]][OP_FORCED_FIXED_FREQ_OPERATION_BIT];

  // ----------------------------------------------------------------
  // Switch gating
  // ----------------------------------------------------------------
  logic pulse_skip_operation, sw_on, skip_reg;
  assign pulse_skip_operation   = !forced_fixed_freq_operation_out;
  assign sw_on = cv_reg == CV_SOFT || cv_reg == CV_RUN;

  // Skip is held until the output sags so light load stops switching.
  // [R16] resume on drop
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) skip_reg <= 1'b0;
    else if (!pulse_skip_operation || vdrop_s) skip_reg <= 1'b0;
    else if (izero_s && boost_region_in) skip_reg <= 1'b1;
  end

  // [R07] overvoltage clamp
  // [R14] high side held
  // [R15] buck low side off
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {buck_hs_on_out, buck_ls_on_out} <= 2'b00;
      {boost_hs_on_out, boost_ls_on_out} <= 2'b00;
    end else if (ovp_s) begin
      {buck_hs_on_out, buck_ls_on_out} <= 2'b01;
      {boost_hs_on_out, boost_ls_on_out} <= 2'b01;
    end else if (!sw_on) begin
      {buck_hs_on_out, buck_ls_on_out} <= 2'b00;
      {boost_hs_on_out, boost_ls_on_out} <= 2'b00;
    end else begin
      buck_hs_on_out  <= pwm_buck_in;
      buck_ls_on_out  <= !pwm_buck_in
                         && !(pulse_skip_operation && !boost_region_in && izero_s);
      boost_ls_on_out <= pwm_boost_in && !(boost_region_in && skip_reg);
      boost_hs_on_out <= !pwm_boost_in && !(pulse_skip_operation && boost_region_in
                         && (izero_s || skip_reg));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ovp;
    ovp_s |=> !buck_hs_on_out && buck_ls_on_out && !boost_hs_on_out
              && boost_ls_on_out;
  endproperty
  a_ovp: assert property (p_ovp) // [R07]
    else $error("overvoltage clamp not applied");

  property p_hiccup_gate;
    (cv_reg != CV_HICCUP && !hiccup_en) |=> cv_reg != CV_HICCUP;
  endproperty
  a_hiccup_gate: assert property (p_hiccup_gate) // [R08]
    else $error("hiccup entered while disabled");

  property p_soft_no_fault;
    cv_reg == CV_SOFT |=> cv_reg != CV_HICCUP;
  endproperty
  a_soft_no_fault: assert property (p_soft_no_fault) // [R09]
    else $error("fault watched during soft start");

  property p_hiccup_end;
    (cv_reg == CV_HICCUP && tmr_reg == TMR_W'(HIC_CYC - 1) && en_s
     && !hot_s && run_bit) |=> cv_reg == CV_SOFT && ref_code_out == 11'h000;
  endproperty
  a_hiccup_end: assert property (p_hiccup_end) // [R10]
    else $error("hiccup off time did not end in soft start");

  property p_thermal;
    (hot_s && en_s) |=> cv_reg == CV_THERMAL ##1 ref_code_out == 11'h000;
  endproperty
  a_thermal: assert property (p_thermal) // [R11]
    else $error("thermal shutdown not taken");

  property p_restart;
    (cv_reg == CV_THERMAL && !hot_s && en_s && run_bit) |=> cv_reg == CV_SOFT;
  endproperty
  a_restart: assert property (p_restart) // [R12]
    else $error("no restart after thermal shutdown");

  property p_forced_fixed_freq_operation_hs;
    (sw_on && !ovp_s && !pulse_skip_operation && !pwm_boost_in && $stable(cv_reg) && en_s
     && !hot_s) |=> boost_hs_on_out;
  endproperty
  a_forced_fixed_freq_operation_hs: assert property (p_forced_fixed_freq_operation_hs) // [R14]
    else $error("high side dropped in fixed frequency mode");

  property p_pfm_buck;
    (pulse_skip_operation && !boost_region_in && izero_s && !ovp_s) |=> !buck_ls_on_out;
  endproperty
  a_pfm_buck: assert property (p_pfm_buck) // [R15]
    else $error("buck low side on at zero current");

  property p_nack;
    (scl_fall && bs_reg == BS_REG && bit_cnt_reg == 4'h8 && !bus_stop
     && !bus_start && en_s && !addr_ok(shift_reg))
    |=> bs_reg == BS_IDLE && !sda_oe_out;
  endproperty
  a_nack: assert property (p_nack) // [R21]
    else $error("undefined address acknowledged");

  property p_en_reset;
    !en_s |=> cfg_reg[REG_OP[2:0]] == CFG_RESET[REG_OP[2:0]]
              && droop_comp_level_out == 3'h0 && cv_reg == CV_IDLE;
  endproperty
  a_en_reset: assert property (p_en_reset) // [R22]
    else $error("registers not reset by enable pin");

  c_hiccup: cover property (cv_reg == CV_RUN ##1 cv_reg == CV_HICCUP);
  c_thermal: cover property (cv_reg == CV_THERMAL ##1 cv_reg == CV_SOFT);
  c_write: cover property (wr_en);
  c_read: cover property (bs_reg == BS_MACK ##[1:200] bs_reg == BS_RDATA);

endmodule // buck_boost_control_sequencer

// ---- tb/i2c_ctrl_model.sv ----
module i2c_ctrl_model (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Bus controller, 1 us bit time
  // ------------------------------------------------------------
  // Both lines start released, so the pull-up holds them high.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Data moves only while the clock is low; it is read late in high.
  // fast-mode-plus bit
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    #200 sda_low_out = ~b;
    #300 scl_out = 1'b1;
    #500 r = sda_in;
  endtask
  // An idle pulse first lets one task serve start and repeated start.
  task automatic start();
    logic r;
    bit_io(1'b1, r);
    sda_low_out = 1'b1;
    #500;
  endtask
  task automatic stop();
    scl_out = 1'b0;
    #200 sda_low_out = 1'b1;
    #300 scl_out = 1'b1;
    #500 sda_low_out = 1'b0;
    #500;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // byte in; a released acknowledge ends a read
  task automatic recv(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
  endtask
endmodule // i2c_ctrl_model

// ---- tb/tb.sv ----
module tb
  import buck_boost_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Short soft-start, fault and hiccup counts keep the run brief.
  // ------------------------------------------------------------
  localparam int SS = 40;
  localparam int SC = 20;
  localparam int HC = 50;
  logic clk, rst_n, en, asel, ovp, ilim, vlow, hot, izero, vdrop, bst;
  logic pb, pbo, fbs, lim_en, forced_fixed_freq_operation, bhs, bls, ohs, ols, ok;
  logic [10:0] ref_o, tgt;
  logic [7:0]  d, q, fbv;
  logic [6:0]  dev, lim;
  logic [2:0]  droop;
  logic [1:0]  ratio;
  wire         scl, sda_low, oe, sda_o;
  int          err_total, comparisons;
  // Open-drain data line with pull-up: low while either party pulls.
  wire sda = ~(sda_low | oe);
  buck_boost_control_sequencer #(.SS_CYC(SS), .SC_CYC(SC), .HIC_CYC(HC))
  buck_boost_control_sequencer_i (
    .sys_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
    .enable_threshold_pin_in(en), .addr_select_in(asel),
    .overvoltage_in(ovp), .current_at_limit_in(ilim),
    .output_below_min_in(vlow), .over_temp_in(hot),
    .inductor_zero_in(izero), .output_dropped_in(vdrop),
    .boost_region_in(bst), .pwm_buck_in(pb), .pwm_boost_in(pbo),
    .sda_out_out(sda_o), .sda_oe_out(oe), .ref_code_out(ref_o),
    .feedback_source_select_out(fbs),
    .internal_divider_ratio_out(ratio), .droop_comp_level_out(droop),
    .current_limit_code_out(lim), .current_limit_en_out(lim_en),
    .forced_fixed_freq_operation_out(forced_fixed_freq_operation),
    .buck_hs_on_out(bhs), .buck_ls_on_out(bls),
    .boost_hs_on_out(ohs), .boost_ls_on_out(ols)
  );
  i2c_ctrl_model i2c_ctrl_model_i (
    .scl_out(scl), .sda_low_out(sda_low), .sda_in(sda)
  );
  // Free-running 10 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic sw();
    return bhs | bls | ohs | ols;
  endfunction
  function automatic logic [10:0] ref_exp(input logic [7:0] lo, hi);
    return {hi[2:0], lo};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input logic [10:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Whole transfers only; ok is low if any byte was refused.
  task automatic wr(input logic [7:0] a, v, output logic k);
    logic k0, k1, k2;
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.send({dev, 1'b0}, k0);
    i2c_ctrl_model_i.send(a, k1);
    i2c_ctrl_model_i.send(v, k2);
    i2c_ctrl_model_i.stop();
    k = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic k;
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.send({dev, 1'b0}, k);
    i2c_ctrl_model_i.send(a, k);
    i2c_ctrl_model_i.start();
    i2c_ctrl_model_i.send({dev, 1'b1}, k);
    i2c_ctrl_model_i.recv(1'b1, v);
    i2c_ctrl_model_i.stop();
  endtask
  task automatic complete_run();
    $display("Mismatches %0d of %0d checks", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence; inputs move only at falling clock edges.
  initial begin
    {rst_n, ovp, ilim, vlow, hot, izero, vdrop, bst, pbo, asel} = '0;
    {en, pb, dev} = {2'b11, 7'h75};
    err_total = 0;
    comparisons = 0;
    void'($urandom(25989));
    wt(2);
    rst_n = 1'b1;
    wt(5);
    for (int a = 0; a < CFG_REGS; a++) begin
      rd(a[7:0], q);
      cmp(q, CFG_RESET[a]);
    end
    cmp(droop, 3'h0);
    cmp(forced_fixed_freq_operation, 1'b0);
    cmp({lim_en, lim}, 8'he4);
    cmp(sda_o, 1'b0);
    // The select pin picks one address; the other must stay silent.
    for (int s = 0; s < 2; s++) begin
      asel = s[0];
      wt(4);
      dev = s[0] ? 7'h74 : 7'h75;
      wr(REG_DROOP, {5'h0, s[0], 2'h1}, ok);
      cmp(ok, 1'b1);
      dev = dev ^ 7'h01;
      wr(REG_DROOP, 8'h07, ok);
      cmp(ok, 1'b0);
      dev = dev ^ 7'h01;
      cmp(droop, {s[0], 2'h1});
    end
    wr(8'h08 + 8'($urandom_range(247)), 8'h00, ok);
    cmp(ok, 1'b0);
    repeat (6) begin
      fbv = 8'($urandom);
      wr(REG_FB, fbv, ok);
      cmp(fbs, fbv[7]);
      cmp(ratio, fbv[1:0]);
      d = 8'($urandom);
      wr(REG_ILIM, d, ok);
      cmp(lim, d[6:0]);
      cmp(lim_en, d[7]);
      rd(REG_FB, q);
      cmp(q & 8'h83, fbv & 8'h83);
    end
    // High byte kept nonzero so the ramp is still short of target.
    d = 8'($urandom);
    wr(REG_REF_LO, d, ok);
    q = {5'h0, 3'($urandom_range(7, 1))};
    wr(REG_REF_HI, q, ok);
    tgt = ref_exp(d, q);
    wr(REG_OP, 8'ha0, ok);
    cmp(ref_o < tgt, 1'b1);
    wt(SS + 10);
    cmp(ref_o, tgt);
    ovp = 1'b1;
    wt(5);
    cmp({bhs, ohs, bls, ols}, 4'b0011);
    ovp = 1'b0;
    {ilim, vlow} = 2'b11;
    wt(SC + 10);
    cmp(sw(), 1'b0);
    wt(30);
    cmp(sw(), 1'b0);
    {ilim, vlow} = 2'b00;
    wt(HC + SS + 20);
    cmp(ref_o, tgt);
    // A fault that lapses briefly must restart the count.
    {ilim, vlow} = 2'b11;
    wt(SC - 5);
    vlow = 1'b0;
    wt(3);
    vlow = 1'b1;
    wt(SC - 5);
    cmp(sw(), 1'b1);
    // Drop the fault, turn hiccup off, then apply the fault again.
    {ilim, vlow} = 2'b00;
    wr(REG_OP, 8'h80, ok);
    {ilim, vlow} = 2'b11;
    wt(SC + 20);
    cmp(sw(), 1'b1);
    {ilim, vlow, hot} = 3'b001;
    wt(5);
    cmp(sw(), 1'b0);
    rd(REG_REF_LO, q);
    cmp(q, d);
    hot = 1'b0;
    wt(5);
    cmp(ref_o < tgt, 1'b1);
    wt(SS + 10);
    cmp(ref_o, tgt);
    {izero, pb} = 2'b10;
    wt(5);
    cmp(bls, 1'b0);
    {bst, pbo} = 2'b10;
    wt(5);
    cmp(ohs, 1'b0);
    izero = 1'b0;
    wt(5);
    cmp(ohs, 1'b0);
    vdrop = 1'b1;
    wt(5);
    cmp(ohs, 1'b1);
    wr(REG_OP, 8'h82, ok);
    cmp(forced_fixed_freq_operation, 1'b1);
    {bst, pbo, izero, vdrop} = 4'b1010;
    wt(5);
    cmp(ohs, 1'b1);
    en = 1'b0;
    wt(5);
    cmp(sw(), 1'b0);
    en = 1'b1;
    wt(5);
    rd(REG_OP, q);
    cmp(q, CFG_RESET[6]);
    complete_run();
  end
  // Watchdog: the sequence needs about 1.3 ms of bus traffic.
  initial begin
    #6_000_000;
    err_total++;
    complete_run();
  end
endmodule // tb
